/* svdc_ctrl.v */
// Supply voltage detector controller: modes, internal reset, interrupt, registers
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "svdc_defines.vh"
module svdc_ctrl (
    input  wire                    clock_in,
    input  wire                    reset_in,
    input  wire                    det_mode_sel_hi_in,
    input  wire                    det_mode_sel_lo_in,
    input  wire                    below_high_level_in,
    input  wire                    below_low_level_in,
    input  wire [`SVDC_ADDR_W-1:0] addr_in,
    input  wire [7:0]              wdata_in,
    input  wire                    write_in,
    input  wire                    read_in,
    output reg  [7:0]              rdata_out,
    output wire                    detector_reset_out,
    output wire                    supply_drop_irq_out,
    output wire                    irq_out
);
    // Comparators: bit 1 high level, bit 0 low or single level
    wire [1:0] cmp_sync;
    wire       below_high;
    wire       below_low;
    wire       below_single;
    wire       single_rise;
    wire       single_fall;
    wire       high_rise;
    wire       high_fall;

    svdc_sync #(
        .WIDTH (2)
    ) u_sync (
        .clock_in (clock_in),
        .reset_in (reset_in),
        .async_in ({below_high_level_in, below_low_level_in}),
        .sync_out (cmp_sync)
    );

    assign below_high   = cmp_sync[1];
    assign below_low    = cmp_sync[0];
    assign below_single = cmp_sync[0];

    svdc_edge u_edge_single (
        .clock_in (clock_in),
        .reset_in (reset_in),
        .level_in (below_single),
        .rise_out (single_fall),
        .fall_out (single_rise)
    );

    svdc_edge u_edge_high (
        .clock_in (clock_in),
        .reset_in (reset_in),
        .level_in (below_high),
        .rise_out (high_fall),
        .fall_out (high_rise)
    );

    // Mode strap caught on the cycle after reset release
    reg        mode_valid_reg;
    reg  [1:0] mode_reg;
    wire       is_intrst;
    wire       is_rst;
    wire       is_int;

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            mode_valid_reg <= 1'b0;
            mode_reg       <= 2'h0;
        end else if (!mode_valid_reg) begin
            mode_valid_reg <= 1'b1;
            mode_reg       <= {det_mode_sel_hi_in, det_mode_sel_lo_in};
        end
    end

    assign is_intrst = mode_valid_reg && (mode_reg == `SVDC_MODE_INTRST);
    assign is_rst    = mode_valid_reg && (mode_reg == `SVDC_MODE_RST);
    assign is_int    = mode_valid_reg && (mode_reg == `SVDC_MODE_INT);

    // Controller state
    localparam ST_HOLD  = 3'b001;
    localparam ST_RUN   = 3'b010;
    localparam ST_RESET = 3'b100;

    reg  [2:0] state_reg;
    reg  [2:0] state_next;
    reg        drop_pulse;
    reg        cause_set;

    always @* begin
        state_next = state_reg;
        drop_pulse = 1'b0;
        cause_set  = 1'b0;
        case (state_reg)
            ST_HOLD: begin
                if (is_int && !below_single) begin
                    state_next = ST_RUN;
                end else if (is_rst && !below_single) begin
                    state_next = ST_RUN;
                end else if (is_intrst && !below_high) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (is_intrst) begin
                    if (below_low) begin
                        state_next = ST_RESET;
                        cause_set  = 1'b1;
                    end else if (high_fall) begin
                        drop_pulse = 1'b1;
                    end
                end else if (is_rst) begin
                    if (below_single) begin
                        state_next = ST_RESET;
                        cause_set  = 1'b1;
                    end
                end else if (is_int) begin
                    if (single_fall || single_rise) begin
                        drop_pulse = 1'b1;
                    end
                end
            end
            ST_RESET: begin
                if (is_intrst && !below_high) begin
                    state_next = ST_RUN;
                end else if (is_rst && !below_single) begin
                    state_next = ST_RUN;
                end else if (is_int) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_HOLD;
            end
        endcase
    end

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= ST_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // Reset held through strap capture and hold, and while a detector reset stands
    assign detector_reset_out  = (state_reg != ST_RUN);
    assign supply_drop_irq_out = drop_pulse;

    // Registers
    reg  [7:0]            level_reg;
    reg                   cause_reg;
    reg  [`SVDC_IRQ_W-1:0] status_reg;
    reg  [`SVDC_IRQ_W-1:0] mask_reg;
    wire                  low_flag;
    wire [`SVDC_IRQ_W-1:0] events;
    reg                   level_init_reg;

    assign low_flag = mode_valid_reg &&
                      (is_intrst && level_reg[`SVDC_BIT_LVLSEL] ? below_low :
                       is_intrst ? below_high : below_single);

    assign events = {cause_set, drop_pulse};

    function [7:0] svdc_level_init;
        input [1:0] mode;
        begin
            case (mode)
                `SVDC_MODE_RST: svdc_level_init = `SVDC_LEVEL_RST_R;
                `SVDC_MODE_INT: svdc_level_init = `SVDC_LEVEL_RST_I;
                default:        svdc_level_init = `SVDC_LEVEL_RST_IR;
            endcase
        end
    endfunction

    wire wr_level  = write_in && (addr_in == `SVDC_ADDR_LEVEL);
    wire wr_mask   = write_in && (addr_in == `SVDC_ADDR_MASK);
    wire wr_cause  = write_in && (addr_in == `SVDC_ADDR_CAUSE);
    wire rd_status = read_in && (addr_in == `SVDC_ADDR_STATUS);

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            level_reg      <= 8'h00;
            level_init_reg <= 1'b0;
        end else if (!level_init_reg && mode_valid_reg) begin
            level_init_reg <= 1'b1;
            level_reg      <= svdc_level_init(mode_reg);
        end else if (drop_pulse) begin
            level_reg[`SVDC_BIT_LVLSEL]  <= 1'b1;
            level_reg[`SVDC_BIT_DETMODE] <= 1'b1;
        end else if (wr_level && is_intrst) begin
            level_reg[`SVDC_BIT_LVLSEL]  <= wdata_in[`SVDC_BIT_LVLSEL];
            level_reg[`SVDC_BIT_DETMODE] <= wdata_in[`SVDC_BIT_DETMODE];
        end
    end

    // Cause flag survives the block reset only as far as this register allows
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            cause_reg <= 1'b0;
        end else if (cause_set) begin
            cause_reg <= 1'b1;
        end else if (wr_cause && !wdata_in[`SVDC_BIT_CAUSE]) begin
            cause_reg <= 1'b0;
        end
    end

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            status_reg <= {`SVDC_IRQ_W{1'b0}};
            mask_reg   <= {`SVDC_IRQ_W{1'b0}};
        end else begin
            // New events win over the clearing read
            status_reg <= (rd_status ? {`SVDC_IRQ_W{1'b0}} : status_reg) | events;
            if (wr_mask) begin
                mask_reg <= wdata_in[`SVDC_IRQ_W-1:0];
            end
        end
    end

    assign irq_out = |(status_reg & mask_reg);

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_out <= 8'h00;
        end else if (read_in) begin
            case (addr_in)
                `SVDC_ADDR_CTRL:   rdata_out <= {7'h00, low_flag};
                `SVDC_ADDR_LEVEL:  rdata_out <= level_reg;
                `SVDC_ADDR_CAUSE:  rdata_out <= {7'h00, cause_reg};
                `SVDC_ADDR_STATUS: rdata_out <= {6'h00, status_reg};
                `SVDC_ADDR_MASK:   rdata_out <= {6'h00, mask_reg};
                default:           rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end
endmodule // svdc_ctrl

/* svdc_ctrl_sva.sv */
// Port assertions for the detector controller
`timescale 1ns/1ps
module svdc_ctrl_sva (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic det_mode_sel_hi_in,
    input wire logic det_mode_sel_lo_in,
    input wire logic below_high_level_in,
    input wire logic below_low_level_in,
    input wire logic detector_reset_out,
    input wire logic supply_drop_irq_out
);
    wire [1:0] mode;
    assign mode = {det_mode_sel_hi_in, det_mode_sel_lo_in};
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    a_low_asserts_reset: assert property ((mode[1] && below_low_level_in) [*5] |->
        detector_reset_out) else $error("low supply did not reset");
    a_single_releases: assert property ((mode[0] && !below_low_level_in) [*5] |->
        !detector_reset_out) else $error("reset kept above the level");
    a_high_releases: assert property ((mode == 2'h2 && !below_high_level_in) [*5] |->
        !detector_reset_out) else $error("reset kept above high level");
    a_no_early_release: assert property (mode == 2'h2 && $fell(detector_reset_out) |->
        !$past(below_high_level_in, 2)) else $error("released below high level");
    a_int_hold_reset: assert property (mode == 2'h1 && $fell(detector_reset_out) |->
        !$past(below_low_level_in, 2)) else $error("released while supply low");
    a_int_no_reassert: assert property (mode == 2'h1 && !detector_reset_out |=>
        !detector_reset_out) else $error("reset asserted in interrupt mode");
    a_cross_raises_irq: assert property (mode == 2'h1 && !detector_reset_out &&
        $changed(below_low_level_in) |-> ##[1:4] supply_drop_irq_out)
        else $error("crossing gave no interrupt");
    a_drop_raises_irq: assert property (mode == 2'h2 && !detector_reset_out &&
        $rose(below_high_level_in) && !below_low_level_in |-> ##[1:4] supply_drop_irq_out)
        else $error("drop gave no interrupt");
    a_irq_one_cycle: assert property (supply_drop_irq_out |=> !supply_drop_irq_out)
        else $error("interrupt pulse too long");
endmodule // svdc_ctrl_sva

bind svdc_ctrl svdc_ctrl_sva svdc_ctrl_sva_i (.clock_in(clock_in), .reset_in(reset_in),
    .det_mode_sel_hi_in(det_mode_sel_hi_in), .det_mode_sel_lo_in(det_mode_sel_lo_in),
    .below_high_level_in(below_high_level_in), .below_low_level_in(below_low_level_in),
    .detector_reset_out(detector_reset_out), .supply_drop_irq_out(supply_drop_irq_out));

/* svdc_defines.vh */
// Constants for the supply voltage detector controller
`ifndef SVDC_DEFINES_VH
`define SVDC_DEFINES_VH
`define SVDC_ADDR_W        4
`define SVDC_ADDR_CTRL     4'h0
`define SVDC_ADDR_LEVEL    4'h1
`define SVDC_ADDR_CAUSE    4'h2
`define SVDC_ADDR_STATUS   4'h3
`define SVDC_ADDR_MASK     4'h4
`define SVDC_BIT_LOWFLAG   0
`define SVDC_BIT_LVLSEL    0
`define SVDC_BIT_DETMODE   7
`define SVDC_BIT_CAUSE     0
`define SVDC_IRQ_DROP      0
`define SVDC_IRQ_RESET     1
`define SVDC_IRQ_W         2
`define SVDC_MODE_INTRST   2'h2
`define SVDC_MODE_RST      2'h3
`define SVDC_MODE_INT      2'h1
`define SVDC_LEVEL_RST_IR  8'h00
`define SVDC_LEVEL_RST_R   8'h81
`define SVDC_LEVEL_RST_I   8'h01
`define SVDC_SYNC_STAGES   2
`endif

/* svdc_edge.v */
// Rise and fall pulse detector on a synchronised level
`timescale 1ns/1ps
module svdc_edge (
    input  wire clock_in,
    input  wire reset_in,
    input  wire level_in,
    output wire rise_out,
    output wire fall_out
);
    reg last_reg;

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            // Matches the synchroniser's reset level so no false edge follows reset
            last_reg <= 1'b1;
        end else begin
            last_reg <= level_in;
        end
    end

    assign rise_out = level_in & ~last_reg;
    assign fall_out = ~level_in & last_reg;
endmodule // svdc_edge

/* svdc_supply_model.sv */
// Supply comparator model driven by a supply level code
`timescale 1ns/1ps
module svdc_supply_model (
    input  wire logic       clock_in,
    input  wire logic [1:0] supply_in,
    output logic            below_high_out,
    output logic            below_low_out
);
    // Code 0 is healthy, 1 lies between the levels, 2 is below the low level
    initial begin
        below_high_out = 1'b0;
        below_low_out  = 1'b0;
    end
    always @(posedge clock_in) begin
        below_high_out <= (supply_in != 2'h0);
        below_low_out  <= (supply_in == 2'h2);
    end
endmodule // svdc_supply_model

/* svdc_sync.v */
// Two flip-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
module svdc_sync #(
    parameter WIDTH = 2
) (
    input  wire             clock_in,
    input  wire             reset_in,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            // Presume the supply low until a real comparison has passed both stages
            meta_reg <= {WIDTH{1'b1}};
            sync_reg <= {WIDTH{1'b1}};
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule // svdc_sync

/* test_svdc_ctrl.sv */
// Self-checking testbench for the detector controller
`timescale 1ns/1ps
`include "svdc_defines.vh"
module test_svdc_ctrl;
    logic       clock_in = 1'b0;
    logic       reset_in = 1'b1;
    logic [1:0] mode     = 2'h0;
    logic [1:0] supply   = 2'h0;
    logic [3:0] addr     = 4'h0;
    logic [7:0] wdata    = 8'h00;
    logic       write    = 1'b0;
    logic       read     = 1'b0;
    logic [7:0] rdata;
    logic       bh;
    logic       bl;
    logic       det_rst;
    logic       drop;
    logic       irq;
    int         n_fail      = 0;
    int         checks_done = 0;
    int         cycles      = 0;
    svdc_ctrl svdc_ctrl_i (.clock_in(clock_in), .reset_in(reset_in),
        .det_mode_sel_hi_in(mode[1]), .det_mode_sel_lo_in(mode[0]),
        .below_high_level_in(bh), .below_low_level_in(bl), .addr_in(addr),
        .wdata_in(wdata), .write_in(write), .read_in(read), .rdata_out(rdata),
        .detector_reset_out(det_rst), .supply_drop_irq_out(drop), .irq_out(irq));
    svdc_supply_model svdc_supply_model_i (.clock_in(clock_in), .supply_in(supply),
        .below_high_out(bh), .below_low_out(bl));
    always #25 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic finish_test;
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock_in);
        addr  <= a;
        wdata <= v;
        write <= 1'b1;
        @(posedge clock_in);
        write <= 1'b0;
        @(negedge clock_in);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock_in);
        addr <= a;
        read <= 1'b1;
        @(posedge clock_in);
        read <= 1'b0;
        @(negedge clock_in);
        chk(rdata, e);
    endtask
    task automatic start(input logic [1:0] m, input logic [1:0] s);
        @(posedge clock_in);
        reset_in <= 1'b1;
        mode     <= m;
        supply   <= s;
        repeat (20) @(posedge clock_in);
        reset_in <= 1'b0;
        repeat (8) @(posedge clock_in);
    endtask
    // Moves the supply and notes whether any interrupt pulse appears over the ten settling cycles
    task automatic move(input logic [1:0] s, input logic e);
        logic hit;
        hit = 1'b0;
        @(posedge clock_in);
        supply <= s;
        repeat (10) begin
            @(negedge clock_in);
            if (drop === 1'b1) hit = 1'b1;
        end
        chk({7'h00, hit}, {7'h00, e});
    endtask
    task automatic t_reset_mode;
        start(`SVDC_MODE_RST, 2'h0);
        chk({7'h00, det_rst}, 8'h00);
        rchk(`SVDC_ADDR_LEVEL, `SVDC_LEVEL_RST_R);
        rchk(`SVDC_ADDR_CAUSE, 8'h00);
        wr(`SVDC_ADDR_MASK, 8'h02);
        move(2'h2, 1'b0);
        chk({6'h00, det_rst, irq}, 8'h03);
        rchk(`SVDC_ADDR_CTRL, 8'h01);
        rchk(`SVDC_ADDR_CAUSE, 8'h01);
        rchk(`SVDC_ADDR_STATUS, 8'h02);
        chk({7'h00, irq}, 8'h00);
        rchk(`SVDC_ADDR_STATUS, 8'h00);
        move(2'h0, 1'b0);
        chk({7'h00, det_rst}, 8'h00);
        rchk(`SVDC_ADDR_CTRL, 8'h00);
        wr(`SVDC_ADDR_CAUSE, 8'h00);
        rchk(`SVDC_ADDR_CAUSE, 8'h00);
        rchk(4'hF, 8'h00);
    endtask
    task automatic t_int_reset_mode;
        start(`SVDC_MODE_INTRST, 2'h0);
        rchk(`SVDC_ADDR_LEVEL, `SVDC_LEVEL_RST_IR);
        wr(`SVDC_ADDR_MASK, 8'h00);
        move(2'h1, 1'b1);
        chk({6'h00, det_rst, irq}, 8'h00);
        rchk(`SVDC_ADDR_LEVEL, 8'h81);
        rchk(`SVDC_ADDR_CTRL, 8'h00);
        wr(`SVDC_ADDR_LEVEL, 8'h00);
        rchk(`SVDC_ADDR_LEVEL, 8'h00);
        rchk(`SVDC_ADDR_CTRL, 8'h01);
        wr(`SVDC_ADDR_MASK, 8'h01);
        chk({7'h00, irq}, 8'h01);
        rchk(`SVDC_ADDR_STATUS, 8'h01);
        chk({7'h00, irq}, 8'h00);
        move(2'h2, 1'b0);
        chk({7'h00, det_rst}, 8'h01);
        move(2'h1, 1'b0);
        chk({7'h00, det_rst}, 8'h01);
        move(2'h0, 1'b0);
        chk({7'h00, det_rst}, 8'h00);
    endtask
    task automatic t_int_mode;
        start(`SVDC_MODE_INT, 2'h2);
        chk({7'h00, det_rst}, 8'h01);
        rchk(`SVDC_ADDR_LEVEL, `SVDC_LEVEL_RST_I);
        move(2'h0, 1'b0);
        chk({7'h00, det_rst}, 8'h00);
        move(2'h2, 1'b1);
        chk({7'h00, det_rst}, 8'h00);
        rchk(`SVDC_ADDR_LEVEL, 8'h81);
        move(2'h0, 1'b1);
        start(2'h0, 2'h0);
        chk({7'h00, det_rst}, 8'h01);
    endtask
    initial begin
        t_reset_mode();
        t_int_reset_mode();
        t_int_mode();
        finish_test();
    end
endmodule // test_svdc_ctrl
